// File: rtl/tuner_host_ctrl.sv
// tuner_host_ctrl: bus master end, takes transfers from software over AXI4-Lite
// assumes one slave on the link and no clock stretching by it
`timescale 1ns/1ps
`include "tuner_defs.svh"
module tuner_host_ctrl #(
  parameter int QTR = `QTR_CYC, // aclk cycles per quarter bit
  parameter int AW = `AXI_AW // register address width
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  i2c_link_if.host link, // two-wire bus
  input wire logic [AW-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [AW-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready // read data ready
);
  import tuner_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic f;
    logic awg;
    logic wg;
    logic [AW-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [31:0] ctrl;
    logic [63:0] tx;
    logic [63:0] rx;
    logic busy;
    logic nack;
    logic cts;
    logic refused;
    host_state_e hs;
    logic [11:0] cnt;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [3:0] frame;
    logic [3:0] len;
    byte_t sh;
    logic rw;
    logic ack;
    logic scl_oe;
    logic sda_oe;
  } state_s;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  state_s s_q;
  state_s s_d;
  logic txf;
  logic tick;
  logic [2:0] ri;
  logic [3:0] ln;

  always_comb begin
    s_d = s_q;
    s_d.s1 = link.sda;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.f = (s_q.s2 & s_q.s3) | (s_q.f & (s_q.s2 ^ s_q.s3));
    txf = (s_q.frame == 4'h0) || !s_q.rw;
    tick = s_q.cnt == 12'h000;
    ri = 3'(s_q.frame - 4'h1);
    ln = s_q.wd[`CT_LEN_LSB +: 4];
    if (s_q.hs != H_IDLE) s_d.cnt = tick ? 12'(QTR - 1) : s_q.cnt - 12'h001;
    if (s_q.hs != H_IDLE && tick) begin
      s_d.ph = s_q.ph + 2'h1;
      case (s_q.hs)
        H_START: begin
          if (s_q.ph == 2'h0) s_d.sda_oe = 1'b1; // sda falls, scl high
          else begin
            s_d.scl_oe = 1'b1;
            s_d.ph = 2'h0;
            s_d.hs = H_FRAME;
          end
        end
        H_FRAME: begin
          case (s_q.ph)
            2'h0: begin
              if (s_q.bitn < 4'h8) s_d.sda_oe = txf & ~s_q.sh[7];
              else s_d.sda_oe = ~txf & (s_q.frame != s_q.len); // last byte unacked
            end
            2'h1: s_d.scl_oe = 1'b0;
            2'h2: begin
              if (s_q.bitn < 4'h8) s_d.sh = {s_q.sh[6:0], s_q.f};
              else s_d.ack = s_q.f;
            end
            default: begin
              s_d.scl_oe = 1'b1;
              s_d.bitn = s_q.bitn + 4'h1;
              if (s_q.bitn == 4'h8) begin
                s_d.bitn = 4'h0;
                if (!txf) begin
                  s_d.rx[8*ri +: 8] = s_q.sh;
                  if (s_q.frame == 4'h1) s_d.cts = s_q.sh[`ST_CTS];
                end
                if (txf && s_q.ack) begin
                  s_d.nack = 1'b1;
                  s_d.hs = H_STOP;
                end else if (s_q.frame == s_q.len) begin
                  s_d.hs = H_STOP;
                end else begin
                  s_d.frame = s_q.frame + 4'h1;
                  // byte 0 goes out as the command, later ones as arguments
                  s_d.sh = s_q.rw ? 8'h00 : s_q.tx[8*s_q.frame[2:0] +: 8];
                end
              end
            end
          endcase
        end
        default: begin
          case (s_q.ph)
            2'h0: s_d.sda_oe = 1'b1;
            2'h1: s_d.scl_oe = 1'b0;
            2'h2: s_d.sda_oe = 1'b0; // sda rises, scl high
            default: begin
              s_d.hs = H_IDLE;
              s_d.busy = 1'b0;
            end
          endcase
        end
      endcase
    end
    if (awvalid && awready) begin
      s_d.awg = 1'b1;
      s_d.wa = awaddr;
    end
    if (wvalid && wready) begin
      s_d.wg = 1'b1;
      s_d.wd = wdata;
      s_d.ws = wstrb;
    end
    if (s_q.bv && bready) s_d.bv = 1'b0;
    if (s_q.awg && s_q.wg) begin
      s_d.awg = 1'b0;
      s_d.wg = 1'b0;
      s_d.bv = 1'b1;
      s_d.br = `RESP_OKAY;
      case (s_q.wa)
        `REG_CTRL: begin
          // a command is refused, not held, until a status read has returned clear-to-send
          if (s_q.busy || (!s_q.wd[`CT_RW_BIT] && ln != 4'h0 && !s_q.cts)) begin
            s_d.refused = 1'b1;
          end else begin
            // transfers go out in software's order
            s_d.refused = 1'b0;
            s_d.ctrl = s_q.wd;
            s_d.busy = 1'b1;
            s_d.nack = 1'b0;
            s_d.hs = H_START;
            s_d.ph = 2'h0;
            s_d.cnt = 12'(QTR - 1);
            s_d.bitn = 4'h0;
            s_d.frame = 4'h0;
            s_d.len = (ln > `XFER_MAX) ? `XFER_MAX : ln;
            s_d.rw = s_q.wd[`CT_RW_BIT];
            // control byte is the address first, then the direction bit
            s_d.sh = {s_q.wd[6:0], s_q.wd[`CT_RW_BIT]};
            if (!s_q.wd[`CT_RW_BIT] && ln != 4'h0) s_d.cts = 1'b0;
          end
        end
        `REG_TXLO: s_d.tx[31:0] = merge(s_q.tx[31:0], s_q.wd, s_q.ws);
        `REG_TXHI: s_d.tx[63:32] = merge(s_q.tx[63:32], s_q.wd, s_q.ws);
        `REG_STAT, `REG_RXLO, `REG_RXHI: ;
        default: s_d.br = `RESP_SLVERR;
      endcase
    end
    if (s_q.rv && rready) s_d.rv = 1'b0;
    if (arvalid && arready) begin
      s_d.rv = 1'b1;
      s_d.rr = `RESP_OKAY;
      s_d.rd = 32'h0000_0000;
      case (araddr)
        `REG_CTRL: s_d.rd = s_q.ctrl;
        `REG_TXLO: s_d.rd = s_q.tx[31:0];
        `REG_TXHI: s_d.rd = s_q.tx[63:32];
        `REG_STAT: begin
          s_d.rd[`SB_BUSY] = s_q.busy;
          s_d.rd[`SB_NACK] = s_q.nack;
          s_d.rd[`SB_CTS] = s_q.cts;
          s_d.rd[`SB_REFUSED] = s_q.refused;
        end
        `REG_RXLO: s_d.rd = s_q.rx[31:0];
        `REG_RXHI: s_d.rd = s_q.rx[63:32];
        default: s_d.rr = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.cts <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready = ~s_q.awg & ~s_q.bv;
  assign wready = ~s_q.wg & ~s_q.bv;
  assign bvalid = s_q.bv;
  assign bresp = s_q.br;
  assign arready = ~s_q.rv;
  assign rvalid = s_q.rv;
  assign rdata = s_q.rd;
  assign rresp = s_q.rr;
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = s_q.scl_oe;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = s_q.sda_oe;
endmodule

// File: rtl/tuner_defs.svh
// tuner_defs.svh: shared constants of the tuner two-wire command link
// assumes inclusion by bare name from both ends
`ifndef TUNER_DEFS_SVH
`define TUNER_DEFS_SVH
`define ADDR_FIXED 5'h18
`define ST_CTS 7
`define ST_INT_W 4
`define CMD_POWERUP 8'h01
`define CMD_POWERDOWN 8'h11
`define PU_BAND_BIT 0
`define PU_EXTCLK_BIT 1
`define RESP_DEPTH 8
`define PIN_SCL 0
`define PIN_SDA 1
`define PIN_RST 2
`define PIN_A0 3
`define PIN_A1 4
`define ACLK_KHZ 200000
`define BUS_MAX_KHZ 400
`define QTR_CYC ((`ACLK_KHZ + 4 * `BUS_MAX_KHZ - 1) / (4 * `BUS_MAX_KHZ))
`define AXI_AW 8
`define REG_CTRL 8'h00
`define REG_TXLO 8'h04
`define REG_TXHI 8'h08
`define REG_STAT 8'h0C
`define REG_RXLO 8'h10
`define REG_RXHI 8'h14
`define CT_RW_BIT 7
`define CT_LEN_LSB 8
`define XFER_MAX 4'h8
`define SB_BUSY 0
`define SB_NACK 1
`define SB_CTS 2
`define SB_REFUSED 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: rtl/tuner_pkg.sv
// tuner_pkg: types shared by both ends of the tuner command link
// assumes nothing beyond a SystemVerilog compiler
package tuner_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_ACK = 3'b010,
    D_RX = 3'b011,
    D_TX = 3'b100,
    D_MACK = 3'b101
  } dev_state_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_FRAME = 2'b10,
    H_STOP = 2'b11
  } host_state_e;
endpackage

// File: rtl/i2c_link_if.sv
// i2c_link_if: the two bus wires between host and tuner, open drain with pull-up
// assumes each end pulls low only while its enable is high and its output is 0
`timescale 1ns/1ps
interface i2c_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface

// File: rtl/tuner_cmd_port.sv
// tuner_cmd_port: device end of the tuner two-wire command port
// assumes aclk far above the bus rate; command execution sits on the user side
`timescale 1ns/1ps
`include "tuner_defs.svh"
module tuner_cmd_port #(
  parameter int RESP_DEPTH = `RESP_DEPTH // response bytes kept, power of two
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  i2c_link_if.dev link, // two-wire bus
  input wire logic chip_reset_low_pin, // chip reset, active low
  input wire logic addr_select_low_pin, // address bit 0, floating reads 1
  input wire logic addr_select_high_pin, // address bit 1, floating reads 1
  output logic interrupt_low_out, // some flag pending, active low
  output tuner_pkg::byte_t cmd_data, // last byte written by the host
  output logic cmd_valid, // pulse: cmd_data is new
  output logic cmd_first, // cmd_data is a command code
  output logic cmd_end, // pulse: write transaction closed
  input wire logic resp_we, // append one response byte
  input tuner_pkg::byte_t resp_data, // response byte
  input wire logic resp_done, // command processed, response complete
  input wire logic [3:0] int_flags, // pending interrupt sources
  output logic proc_en, // processing powered up
  output logic band_fm, // 1 fm, 0 am
  output logic ext_refclk // 1 external reference, 0 crystal
);
  import tuner_pkg::*;
  localparam int IW = $clog2(RESP_DEPTH);
  localparam int PW = IW + 1;
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] f;
    dev_state_e st;
    logic [3:0] bits;
    byte_t sh;
    logic rw;
    logic oe;
    logic nack;
    logic cts;
    logic [1:0] idx;
    logic [PW-1:0] rp;
    logic [PW-1:0] wp;
    byte_t cmd;
    byte_t arg;
    logic pwr;
    logic band;
    logic ext;
    byte_t rxd;
    logic rxv;
    logic rxf;
    logic endp;
    logic irqn;
    logic [RESP_DEPTH-1:0][7:0] mem;
  } state_s;

  function automatic state_s rst_state();
    state_s r;
    r = '0;
    r.cts = 1'b1;
    r.irqn = 1'b1;
    return r;
  endfunction

  state_s s_q;
  state_s s_d;
  logic [4:0] fn;
  logic scl_r;
  logic scl_fl;
  logic start_c;
  logic stop_c;
  logic match_c;
  logic load_c;
  byte_t tx_c;
  logic [PW-1:0] ri;

  always_comb begin
    s_d = s_q;
    // a pin change counts once the second and third stages agree
    fn = (s_q.s2 & s_q.s3) | (s_q.f & (s_q.s2 ^ s_q.s3));
    scl_r = fn[`PIN_SCL] & ~s_q.f[`PIN_SCL];
    scl_fl = ~fn[`PIN_SCL] & s_q.f[`PIN_SCL];
    start_c = fn[`PIN_SCL] & s_q.f[`PIN_SCL] & s_q.f[`PIN_SDA] & ~fn[`PIN_SDA];
    stop_c = fn[`PIN_SCL] & s_q.f[`PIN_SCL] & ~s_q.f[`PIN_SDA] & fn[`PIN_SDA];
    // fixed upper part, pins give bit 1 and bit 0
    match_c = s_q.sh[7:1] == {`ADDR_FIXED, s_q.f[`PIN_A1], s_q.f[`PIN_A0]};
    ri = s_q.rp - 1'b1;
    tx_c = 8'h00;
    if (s_q.rp == '0) begin
      tx_c[`ST_CTS] = s_q.cts;
      tx_c[`ST_INT_W-1:0] = int_flags;
    end else if (s_q.cts && ri < s_q.wp) begin
      // stale or partial bytes never leave while the command runs
      tx_c = s_q.mem[ri[IW-1:0]];
    end
    load_c = 1'b0;
    s_d.rxv = 1'b0;
    s_d.endp = 1'b0;
    s_d.irqn = ~|int_flags;
    if (start_c) begin
      s_d.st = D_ADDR;
      s_d.bits = 4'h0;
      s_d.oe = 1'b0;
    end else if (stop_c) begin
      s_d.st = D_IDLE;
      s_d.oe = 1'b0;
      if (!s_q.rw && s_q.idx != 2'h0) begin
        s_d.endp = 1'b1;
        s_d.cts = 1'b0;
        s_d.wp = '0;
        if (s_q.cmd == `CMD_POWERUP) begin
          s_d.pwr = 1'b1;
          if (s_q.idx == 2'h2) begin
            s_d.band = s_q.arg[`PU_BAND_BIT];
            s_d.ext = s_q.arg[`PU_EXTCLK_BIT];
          end
        end else if (s_q.cmd == `CMD_POWERDOWN) begin
          s_d.pwr = 1'b0; // only processing stops, the port keeps answering
        end
      end
      s_d.idx = 2'h0;
    end else if (scl_r) begin
      case (s_q.st)
        D_ADDR, D_RX: begin
          s_d.sh = {s_q.sh[6:0], fn[`PIN_SDA]};
          s_d.bits = s_q.bits + 4'h1;
        end
        D_MACK: s_d.nack = fn[`PIN_SDA];
        default: ;
      endcase
    end else if (scl_fl) begin
      case (s_q.st)
        D_ADDR: begin
          if (s_q.bits == 4'h8) begin
            if (match_c) begin
              s_d.oe = 1'b1;
              s_d.rw = s_q.sh[0];
              s_d.st = D_ACK;
              s_d.rp = '0;
              if (!s_q.sh[0]) s_d.idx = 2'h0;
            end else begin
              s_d.st = D_IDLE;
            end
          end
        end
        D_RX: begin
          if (s_q.bits == 4'h8) begin
            s_d.oe = 1'b1;
            s_d.st = D_ACK;
            s_d.rxv = 1'b1;
            s_d.rxd = s_q.sh;
            s_d.rxf = s_q.idx == 2'h0;
            if (s_q.idx == 2'h0) s_d.cmd = s_q.sh;
            if (s_q.idx == 2'h1) s_d.arg = s_q.sh;
            if (s_q.idx != 2'h2) s_d.idx = s_q.idx + 2'h1;
          end
        end
        D_ACK: begin
          s_d.bits = 4'h0;
          if (s_q.rw) begin
            load_c = 1'b1;
          end else begin
            s_d.oe = 1'b0;
            s_d.st = D_RX;
          end
        end
        D_TX: begin
          if (s_q.bits == 4'h7) begin
            s_d.oe = 1'b0;
            s_d.st = D_MACK;
          end else begin
            s_d.sh = {s_q.sh[6:0], 1'b0};
            s_d.oe = ~s_q.sh[6];
            s_d.bits = s_q.bits + 4'h1;
          end
        end
        D_MACK: begin
          if (s_q.nack) s_d.st = D_IDLE;
          else load_c = 1'b1;
        end
        default: ;
      endcase
    end
    if (load_c) begin
      s_d.sh = tx_c;
      s_d.oe = ~tx_c[7];
      s_d.bits = 4'h0;
      s_d.st = D_TX;
      if (s_q.rp != '1) s_d.rp = s_q.rp + 1'b1;
    end
    if (resp_we && s_q.wp < PW'(RESP_DEPTH)) begin
      s_d.mem[s_q.wp[IW-1:0]] = resp_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    // coming after the clear at stop, a completion in that cycle is not lost
    if (resp_done) s_d.cts = 1'b1;
    if (!s_q.f[`PIN_RST]) s_d = rst_state();
    s_d.s1 = {addr_select_high_pin, addr_select_low_pin, chip_reset_low_pin, link.sda,
              link.scl};
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.f = fn;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) s_q <= rst_state();
    else s_q <= s_d;
  end

  // open drain: the device only ever pulls data low and has no clock driver
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = s_q.oe;
  assign interrupt_low_out = s_q.irqn;
  assign cmd_data = s_q.rxd;
  assign cmd_valid = s_q.rxv;
  assign cmd_first = s_q.rxf;
  assign cmd_end = s_q.endp;
  assign proc_en = s_q.pwr;
  assign band_fm = s_q.band;
  assign ext_refclk = s_q.ext;
endmodule

// File: tb/tuner_link_properties.sv
// tuner_link_properties: timing checks on the two wires between host and tuner
// assumes the bench hands over the interface signals and the host's quarter-bit count
`timescale 1ns/1ps
module tuner_link_properties #(
  parameter int QTR = 16 // aclk cycles per quarter bit
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic host_sda_oe, // host pulls sda low
  input wire logic dev_sda_oe, // device pulls sda low
  input wire logic scl, // resolved clock wire
  input wire logic sda // resolved data wire
);
  localparam int QW = QTR + 4;
  localparam int REL = 40 * QTR;
  localparam int LOW_MIN = 2 * QTR - 2;
  logic [9:0] low_cnt; // cycles since scl fell, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn || scl) begin
      low_cnt <= 10'h000;
    end else if (low_cnt != 10'h3FF) begin
      low_cnt <= low_cnt + 10'h001;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_dev_after_fall;
    $changed(dev_sda_oe) |-> !scl && low_cnt inside {[1:8]};
  endproperty
  a_dev_after_fall: assert property (p_dev_after_fall)
    else $error("device moved sda away from an scl fall");
  property p_ack_hold;
    $rose(dev_sda_oe) |-> dev_sda_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("device low pulse too short");
  property p_dev_release;
    $rose(dev_sda_oe) |-> ##[1:REL] !dev_sda_oe;
  endproperty
  a_dev_release: assert property (p_dev_release)
    else $error("device kept sda low too long");
  property p_dev_stable_high;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  a_dev_stable_high: assert property (p_dev_stable_high)
    else $error("device changed sda while scl high");
  property p_start_clock;
    $fell(sda) && scl |-> ##[1:QW] !scl;
  endproperty
  a_start_clock: assert property (p_start_clock)
    else $error("no clock after start");
  property p_start_by_host;
    $fell(sda) && scl |-> host_sda_oe && !dev_sda_oe;
  endproperty
  a_start_by_host: assert property (p_start_by_host)
    else $error("start not made by the host");
  property p_stop_idle;
    $rose(sda) && scl |-> (scl && !dev_sda_oe) [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("bus not idle after stop");
  property p_scl_low_time;
    $rose(scl) |-> low_cnt >= LOW_MIN;
  endproperty
  a_scl_low_time: assert property (p_scl_low_time)
    else $error("scl low phase too short");
endmodule

// File: tb/tb_tuner_i2c_command_port.sv
// tb_tuner_i2c_command_port: host controller and tuner port joined over the link
// assumes the defines header, package, interface and both ends are compiled first
`timescale 1ns/1ps
`include "tuner_defs.svh"
module tb_tuner_i2c_command_port;
  import tuner_pkg::*;
  // short quarter bit keeps the run small; the link then runs above its real rate
  localparam int QTR = 16;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [3:0] wstrb, int_flags;
  logic [1:0] bresp, rresp, resp_q;
  logic chip_reset_low_pin, addr_select_low_pin, addr_select_high_pin, interrupt_low_out;
  logic cmd_valid, cmd_first, cmd_end, resp_we, resp_done, proc_en, band_fm, ext_refclk;
  byte_t cmd_data, resp_data;
  logic host_cts, dev_cts;
  logic [7:0] rsp[$];
  logic [8:0] got_q[$];
  int bad_count, total_checks, cyc, end_count, exp_end;
  i2c_link_if i_i2c_link_if();
  tuner_host_ctrl #(.QTR(QTR)) i_tuner_host_ctrl (.aclk, .aresetn, .link(i_i2c_link_if),
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  tuner_cmd_port i_tuner_cmd_port (.aclk, .aresetn, .link(i_i2c_link_if), .chip_reset_low_pin,
    .addr_select_low_pin, .addr_select_high_pin, .interrupt_low_out, .cmd_data, .cmd_valid,
    .cmd_first, .cmd_end, .resp_we, .resp_data, .resp_done, .int_flags, .proc_en, .band_fm,
    .ext_refclk);
  tuner_link_properties #(.QTR(QTR)) i_tuner_link_properties (.aclk, .aresetn,
    .host_sda_oe(i_i2c_link_if.host_sda_oe), .dev_sda_oe(i_i2c_link_if.dev_sda_oe),
    .scl(i_i2c_link_if.scl), .sda(i_i2c_link_if.sda));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // a whole run needs about 40k cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      give_verdict();
    end
  end
  // pulses are one cycle wide, so the falling edge sees each exactly once
  always @(negedge aclk) begin
    if (cmd_valid === 1'b1) begin
      got_q.push_back({cmd_first, cmd_data});
    end
    if (cmd_end === 1'b1) begin
      end_count++;
    end
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, b_hit;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hit = 1'b0;
    while (!b_hit) begin
      @(negedge aclk);
      aw_hit = awvalid & awready;
      w_hit = wvalid & wready;
      b_hit = bvalid;
      resp_q = bresp;
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar_hit, r_hit;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hit = 1'b0;
    while (!r_hit) begin
      @(negedge aclk);
      ar_hit = arvalid & arready;
      r_hit = rvalid;
      rd_q = rdata;
      resp_q = rresp;
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  function automatic logic [7:0] exp_byte(input int k);
    if (k == 0) return {dev_cts, 3'b000, int_flags};
    if (dev_cts && k <= rsp.size()) return rsp[k-1];
    return 8'h00;
  endfunction
  task automatic xfer(input logic [6:0] adr, input logic rd, input int len,
                      input logic [63:0] tx, input logic nack);
    logic [63:0] rx;
    axi_wr(`REG_TXLO, tx[31:0]);
    axi_wr(`REG_TXHI, tx[63:32]);
    axi_wr(`REG_CTRL, {20'h0, len[3:0], rd, adr});
    check("ctrl write response", resp_q, `RESP_OKAY);
    rd_q = 32'h1;
    while (rd_q[`SB_BUSY] === 1'b1) begin
      axi_rd(`REG_STAT);
    end
    if (!rd && !nack) begin
      host_cts = 1'b0;
      dev_cts = 1'b0;
      rsp.delete();
    end
    if (rd && !nack) host_cts = dev_cts;
    check("status", rd_q, {28'h0, 1'b0, host_cts, nack, 1'b0});
    if (!rd && !nack) begin
      check("command count", got_q.size(), len);
      exp_end++;
      check("command end", end_count, exp_end);
      for (int k = 0; k < len && got_q.size() > 0; k++) begin
        check("command byte", got_q.pop_front(), {k == 0, tx[8*k +: 8]});
      end
    end
    if (rd && !nack) begin
      axi_rd(`REG_RXLO);
      rx[31:0] = rd_q;
      axi_rd(`REG_RXHI);
      rx[63:32] = rd_q;
      for (int k = 0; k < len; k++) begin
        check("read byte", rx[8*k +: 8], exp_byte(k));
      end
    end
  endtask
  task automatic respond(input int n);
    logic [7:0] b;
    for (int j = 0; j < n; j++) begin
      @(posedge aclk);
      b = 8'($urandom);
      resp_we <= 1'b1;
      resp_data <= b;
      rsp.push_back(b);
    end
    @(posedge aclk);
    resp_we <= 1'b0;
    resp_done <= 1'b1;
    dev_cts = 1'b1;
    @(posedge aclk);
    resp_done <= 1'b0;
  endtask
  initial begin
    logic [7:0] arg;
    logic [6:0] adr;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, resp_we, resp_done} = 8'h00;
    {awaddr, araddr, wdata, resp_data, int_flags} = 60'h0;
    {chip_reset_low_pin, addr_select_low_pin, addr_select_high_pin} = 3'h7;
    wstrb = 4'hF;
    host_cts = 1'b1;
    dev_cts = 1'b1;
    void'($urandom(32'hc39a2596));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    axi_rd(`REG_STAT);
    check("reset status", rd_q, 32'h4);
    axi_rd(8'hFC);
    check("unmapped response", resp_q, `RESP_SLVERR);
    check("unmapped data", rd_q, 32'h0);
    axi_wr(8'hFC, 32'h0);
    check("unmapped write", resp_q, `RESP_SLVERR);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      {addr_select_high_pin, addr_select_low_pin} <= 2'(k);
      int_flags <= 4'($urandom);
      adr = {5'h18, 2'(k)};
      xfer({5'h18, ~adr[1:0]}, 1'b1, 1, 64'h0, 1'b1);
      arg = 8'($urandom_range(3));
      xfer(adr, 1'b0, 2, {48'h0, arg, `CMD_POWERUP}, 1'b0);
      check("powered", proc_en, 1'b1);
      check("band", band_fm, arg[0]);
      check("clock source", ext_refclk, arg[1]);
      if (k == 0) begin
        axi_wr(`REG_CTRL, {20'h0, 4'h1, 1'b0, adr});
        axi_rd(`REG_STAT);
        check("refused status", rd_q, 32'h8);
      end
      xfer(adr, 1'b1, 2, 64'h0, 1'b0);
      respond(3);
      xfer(adr, 1'b1, 5, 64'h0, 1'b0);
      check("interrupt", interrupt_low_out, int_flags == 4'h0);
      $display("test address %0d done", k);
    end
    xfer(adr, 1'b0, 1, {56'h0, `CMD_POWERDOWN}, 1'b0);
    check("powered down", proc_en, 1'b0);
    respond(1);
    xfer(adr, 1'b1, 2, 64'h0, 1'b0);
    $display("test powerdown done");
    // known nonzero settings, so that the reset below has something to clear
    xfer(adr, 1'b0, 2, {48'h0, 8'h03, `CMD_POWERUP}, 1'b0);
    check("band fm", band_fm, 1'b1);
    chip_reset_low_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    xfer(adr, 1'b1, 1, 64'h0, 1'b1);
    check("band in reset", band_fm, 1'b0);
    check("clock in reset", ext_refclk, 1'b0);
    check("power in reset", proc_en, 1'b0);
    chip_reset_low_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    dev_cts = 1'b1;
    rsp.delete();
    xfer(adr, 1'b1, 2, 64'h0, 1'b0);
    $display("test chip reset done");
    give_verdict();
  end
endmodule
